// file: shared/omc_map.svh
// address map, field positions, reset values and timing figures
`ifndef OMC_MAP_SVH
`define OMC_MAP_SVH

// ---------------------------------------------------------------
// clock and timing figures
// ---------------------------------------------------------------
`define OMC_CLK_PERIOD_NS 5
`define OMC_NS_PER_US 1000
`define OMC_NS_PER_MS 64'd1000000
`define OMC_NS_PER_S 64'd1000000000
`define OMC_T_RESET_US 10
`define OMC_T_RESET_CYC ((`OMC_T_RESET_US*`OMC_NS_PER_US+`OMC_CLK_PERIOD_NS-1)/`OMC_CLK_PERIOD_NS)
`define OMC_RST_CNT_W 12
`define OMC_T_START_UP_MS 300
`define OMC_T_START_UP_CYC (`OMC_T_START_UP_MS*`OMC_NS_PER_MS/`OMC_CLK_PERIOD_NS)
`define OMC_T_2W_MS 300
`define OMC_T_2W_CYC (`OMC_T_2W_MS*`OMC_NS_PER_MS/`OMC_CLK_PERIOD_NS)
`define OMC_T_HP_MS 300
`define OMC_T_HP_CYC (`OMC_T_HP_MS*`OMC_NS_PER_MS/`OMC_CLK_PERIOD_NS)
`define OMC_T_COOLED_S 90
`define OMC_T_COOLED_CYC (`OMC_T_COOLED_S*`OMC_NS_PER_S/`OMC_CLK_PERIOD_NS)
`define OMC_TMR_W 36

// ---------------------------------------------------------------
// register bus
// ---------------------------------------------------------------
`define OMC_AW 8
`define OMC_DW 32
`define OMC_OFF_CTRL 8'h00
`define OMC_OFF_STATUS 8'h04
`define OMC_OFF_EVENT 8'h08
`define OMC_OFF_EVCLR 8'h0c
`define OMC_OFF_EVEN 8'h10
`define OMC_OFF_ID 8'h40
`define OMC_ID_AW 4
`define OMC_ID_MSB 5
`define OMC_ID_LSB 2
`define OMC_ID_BASE_MSB 7
`define OMC_ID_BASE_LSB 6
`define OMC_RESP_OKAY 2'h0
`define OMC_RESP_SLVERR 2'h2
`define OMC_SEL_W 3
`define OMC_SEL_CTRL 3'h0
`define OMC_SEL_STATUS 3'h1
`define OMC_SEL_EVENT 3'h2
`define OMC_SEL_EVCLR 3'h3
`define OMC_SEL_EVEN 3'h4
`define OMC_SEL_ID 3'h5
`define OMC_SEL_NONE 3'h7

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define OMC_CTRL_W 2
`define OMC_CTRL_HP 0
`define OMC_CTRL_SOFT_OFF 1
`define OMC_CTRL_RST 2'h0
`define OMC_EV_W 6
`define OMC_EV_FAULT 0
`define OMC_EV_LOS_ON 1
`define OMC_EV_LOS_OFF 2
`define OMC_EV_SER_RDY 3
`define OMC_EV_OPER 4
`define OMC_EV_HP 5
`define OMC_EV_RST 6'h00
`define OMC_ST_W 11
`define OMC_ST_FAULT 0
`define OMC_ST_LOS 1
`define OMC_ST_OPER 2
`define OMC_ST_SER_RDY 3
`define OMC_ST_HP 4
`define OMC_ST_LASER 5
`define OMC_ST_OFF_REQ 6
`define OMC_ST_RX_RATE 7
`define OMC_ST_TX_RATE 8
`define OMC_ST_FAULT_PIN 9
`define OMC_ST_LOS_PIN 10

`endif

// file: shared/omc_pkg.sv
// types shared by the optical module control logic
package omc_pkg;

  // transmitter state
  typedef enum logic [1:0] {
    ls_warm = 2'b00,
    ls_run = 2'b01,
    ls_fault = 2'b10
  } omc_laser_t;

endpackage

// file: rtl/omc_timer.sv
// one-shot down counter that flags expiry
`timescale 1ns/1ps
`default_nettype none
`include "omc_map.svh"

module omc_timer
  import omc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  // control
  input wire logic start,
  input wire logic [`OMC_TMR_W-1:0] load_val,
  // status
  output logic done
);

  localparam logic [`OMC_TMR_W-1:0] tmr_one = `OMC_TMR_W'(1);

  logic [`OMC_TMR_W-1:0] count;

  // load on start, then count down to expiry
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      count <= '0;
      done <= 1'h0;
    end else if (ce) begin
      if (start) begin
        count <= load_val;
        done <= 1'h0;
      end else if (!done) begin
        if (count <= tmr_one) begin
          done <= 1'h1;
        end else begin
          count <= count - tmr_one;
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: rtl/omc_idmem.sv
// identification memory with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "omc_map.svh"

module omc_idmem
  import omc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  // write port
  input wire logic we,
  input wire logic [`OMC_ID_AW-1:0] waddr,
  input wire logic [`OMC_DW-1:0] wdata,
  input wire logic [`OMC_DW/8-1:0] wstrb,
  // read port
  input wire logic re,
  input wire logic [`OMC_ID_AW-1:0] raddr,
  output logic [`OMC_DW-1:0] rdata
);

  logic [`OMC_DW-1:0] mem [0:(1<<`OMC_ID_AW)-1];

  // byte-lane writes
  always_ff @(posedge ref_clk) begin
    if (ce && we) begin
      for (int b = 0; b < `OMC_DW/8; b++) begin
        if (wstrb[b]) begin
          mem[waddr][b*8 +: 8] <= wdata[b*8 +: 8];
        end
      end
    end
  end

  // registered read
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdata <= '0;
    end else if (ce && re) begin
      rdata <= mem[raddr];
    end
  end

endmodule
`default_nettype wire

// file: rtl/omc_ctrl.sv
// control, status and register file of the optical module
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "omc_map.svh"

module omc_ctrl
  import omc_pkg::*;
#(
  parameter logic COOLED = 1'h1,
  parameter logic [`OMC_TMR_W-1:0] START_CYCLES =
    `OMC_TMR_W'(`OMC_T_START_UP_CYC),
  parameter logic [`OMC_TMR_W-1:0] COOLED_CYCLES =
    `OMC_TMR_W'(`OMC_T_COOLED_CYC),
  parameter logic [`OMC_TMR_W-1:0] SERIAL_READY_DELAY =
    `OMC_TMR_W'(`OMC_T_2W_CYC),
  parameter logic [`OMC_TMR_W-1:0] HIGH_POWER_ENTRY_DELAY =
    `OMC_TMR_W'(`OMC_T_HP_CYC)
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  // axi4-lite write address
  input wire logic [`OMC_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [`OMC_DW-1:0] s_axi_wdata,
  input wire logic [`OMC_DW/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [`OMC_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [`OMC_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // host-facing pins
  input wire logic laser_off_request,
  input wire logic rx_rate_pick,
  input wire logic tx_rate_pick,
  output logic module_missing,
  // open-drain fault pin
  input wire logic laser_fault_flag_in,
  output logic laser_fault_flag_out,
  output logic laser_fault_flag_oe,
  // open-drain loss-of-signal pin
  input wire logic optical_input_lost_in,
  output logic optical_input_lost_out,
  output logic optical_input_lost_oe,
  // optics side
  input wire logic laser_fault_detect,
  input wire logic rx_power_low,
  output logic laser_enable,
  output logic rx_rate_sel,
  output logic power_level2,
  output logic serial_ready,
  // interrupt
  output logic irq
);

  // -------------------------------------------------------------
  // decode helpers
  // -------------------------------------------------------------

  // base of the identification window, named so it can be sliced
  localparam logic [`OMC_AW-1:0] id_base = `OMC_OFF_ID;

  // map a byte address onto a register select code
  function automatic logic [`OMC_SEL_W-1:0] reg_sel(
    input logic [`OMC_AW-1:0] a
  );
    if (a == `OMC_OFF_CTRL) begin
      reg_sel = `OMC_SEL_CTRL;
    end else if (a == `OMC_OFF_STATUS) begin
      reg_sel = `OMC_SEL_STATUS;
    end else if (a == `OMC_OFF_EVENT) begin
      reg_sel = `OMC_SEL_EVENT;
    end else if (a == `OMC_OFF_EVCLR) begin
      reg_sel = `OMC_SEL_EVCLR;
    end else if (a == `OMC_OFF_EVEN) begin
      reg_sel = `OMC_SEL_EVEN;
    end else if (a[`OMC_ID_BASE_MSB:`OMC_ID_BASE_LSB] ==
                 id_base[`OMC_ID_BASE_MSB:`OMC_ID_BASE_LSB] &&
                 a[`OMC_ID_LSB-1:0] == 2'h0) begin
      reg_sel = `OMC_SEL_ID;
    end else begin
      reg_sel = `OMC_SEL_NONE;
    end
  endfunction

  // word index inside the identification window
  function automatic logic [`OMC_ID_AW-1:0] id_idx(
    input logic [`OMC_AW-1:0] a
  );
    id_idx = a[`OMC_ID_MSB:`OMC_ID_LSB];
  endfunction

  localparam logic [`OMC_RST_CNT_W-1:0] reset_cyc =
    `OMC_RST_CNT_W'(`OMC_T_RESET_CYC);

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  omc_laser_t state;
  omc_laser_t next_state;
  logic [`OMC_RST_CNT_W-1:0] off_cnt;
  logic boot;
  logic warm_start;
  logic [`OMC_CTRL_W-1:0] ctrl;
  logic [`OMC_EV_W-1:0] event_q;
  logic [`OMC_EV_W-1:0] ev_en;
  logic [`OMC_EV_W-1:0] next_event;
  logic [`OMC_EV_W-1:0] ev_set;
  logic [`OMC_EV_W-1:0] ev_clr;
  logic [`OMC_ST_W-1:0] status;
  logic fault_q, los_q, sr_q, oper_q, hp_q;
  logic [`OMC_AW-1:0] aw_addr;
  logic [`OMC_DW-1:0] w_data;
  logic [`OMC_DW/8-1:0] w_strb;
  logic [`OMC_AW-1:0] rd_addr;
  logic rd_pend;
  logic [`OMC_DW-1:0] mem_rdata;
  logic [`OMC_DW-1:0] rd_word;
  logic st_done, sr_done, hp_done;

  // -------------------------------------------------------------
  // bus decode
  // -------------------------------------------------------------
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire b_fire = s_axi_bvalid && s_axi_bready;
  wire r_fire = s_axi_rvalid && s_axi_rready;
  wire wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire [`OMC_SEL_W-1:0] wr_sel = reg_sel(aw_addr);
  wire [`OMC_SEL_W-1:0] rd_sel = reg_sel(rd_addr);
  wire lane0 = w_strb[0];
  wire wr_ctrl = wr_fire && wr_sel == `OMC_SEL_CTRL && lane0;
  wire wr_evclr = wr_fire && wr_sel == `OMC_SEL_EVCLR && lane0;
  wire wr_even = wr_fire && wr_sel == `OMC_SEL_EVEN && lane0;
  wire wr_bad = wr_sel == `OMC_SEL_NONE;
  wire mem_we = wr_fire && wr_sel == `OMC_SEL_ID;
  // memory answers only once the serial side is up
  wire rd_bad = rd_sel == `OMC_SEL_NONE ||
                (rd_sel == `OMC_SEL_ID && !serial_ready);
  wire s_axi_wdata_hp = w_data[`OMC_CTRL_HP];
  wire hp_start = wr_ctrl && s_axi_wdata_hp && !ctrl[`OMC_CTRL_HP];

  // read data selection
  assign rd_word =
    rd_bad ? '0 :
    rd_sel == `OMC_SEL_CTRL ?
      {{(`OMC_DW-`OMC_CTRL_W){1'b0}}, ctrl} :
    rd_sel == `OMC_SEL_STATUS ?
      {{(`OMC_DW-`OMC_ST_W){1'b0}}, status} :
    rd_sel == `OMC_SEL_EVENT ?
      {{(`OMC_DW-`OMC_EV_W){1'b0}}, event_q} :
    rd_sel == `OMC_SEL_EVEN ?
      {{(`OMC_DW-`OMC_EV_W){1'b0}}, ev_en} :
    rd_sel == `OMC_SEL_ID ? mem_rdata : '0;

  // -------------------------------------------------------------
  // axi4-lite write channel
  // -------------------------------------------------------------

  // address and data are caught independently, answered together
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_axi_awready <= 1'h1;
      s_axi_wready <= 1'h1;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= `OMC_RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else if (ce) begin
      if (aw_fire) begin
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'h0;
      end
      if (w_fire) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'h0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'h1;
        s_axi_bresp <= wr_bad ? `OMC_RESP_SLVERR : `OMC_RESP_OKAY;
      end
      if (b_fire) begin
        s_axi_bvalid <= 1'h0;
        s_axi_awready <= 1'h1;
        s_axi_wready <= 1'h1;
      end
    end
  end

  // -------------------------------------------------------------
  // axi4-lite read channel
  // -------------------------------------------------------------

  // one cycle for the memory, then the answer
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_axi_arready <= 1'h1;
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `OMC_RESP_OKAY;
      rd_addr <= '0;
      rd_pend <= 1'h0;
    end else if (ce) begin
      if (ar_fire) begin
        rd_addr <= s_axi_araddr;
        rd_pend <= 1'h1;
        s_axi_arready <= 1'h0;
      end
      if (rd_pend) begin
        rd_pend <= 1'h0;
        s_axi_rvalid <= 1'h1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_bad ? `OMC_RESP_SLVERR : `OMC_RESP_OKAY;
      end
      if (r_fire) begin
        s_axi_rvalid <= 1'h0;
        s_axi_arready <= 1'h1;
      end
    end
  end

  // -------------------------------------------------------------
  // control and interrupt registers
  // -------------------------------------------------------------
  assign ev_clr = wr_evclr ? w_data[`OMC_EV_W-1:0] : '0;
  // a new event wins over a clear in the same cycle
  assign next_event = (event_q & ~ev_clr) | ev_set;
  // enable as it stands after this edge, so irq never lags a write
  wire [`OMC_EV_W-1:0] next_en = wr_even ? w_data[`OMC_EV_W-1:0] : ev_en;

  // software registers, sticky events, interrupt level
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ctrl <= `OMC_CTRL_RST;
      ev_en <= `OMC_EV_RST;
      event_q <= `OMC_EV_RST;
      irq <= 1'h0;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl <= w_data[`OMC_CTRL_W-1:0];
      end
      if (wr_even) begin
        ev_en <= w_data[`OMC_EV_W-1:0];
      end
      event_q <= next_event;
      irq <= |(next_event & next_en);
    end
  end

  // -------------------------------------------------------------
  // status and event sources
  // -------------------------------------------------------------
  wire fault = state == ls_fault;
  wire oper = state == ls_run;
  wire los = !optical_input_lost_oe;

  // live status word
  assign status[`OMC_ST_FAULT] = fault;
  assign status[`OMC_ST_LOS] = los;
  assign status[`OMC_ST_OPER] = oper;
  assign status[`OMC_ST_SER_RDY] = serial_ready;
  assign status[`OMC_ST_HP] = power_level2;
  assign status[`OMC_ST_LASER] = laser_enable;
  assign status[`OMC_ST_OFF_REQ] = laser_off_request;
  assign status[`OMC_ST_RX_RATE] = rx_rate_pick;
  assign status[`OMC_ST_TX_RATE] = tx_rate_pick;
  assign status[`OMC_ST_FAULT_PIN] = laser_fault_flag_in;
  assign status[`OMC_ST_LOS_PIN] = optical_input_lost_in;

  // edges that raise sticky events
  assign ev_set[`OMC_EV_FAULT] = fault && !fault_q;
  assign ev_set[`OMC_EV_LOS_ON] = los && !los_q;
  assign ev_set[`OMC_EV_LOS_OFF] = !los && los_q;
  assign ev_set[`OMC_EV_SER_RDY] = serial_ready && !sr_q;
  assign ev_set[`OMC_EV_OPER] = oper && !oper_q;
  assign ev_set[`OMC_EV_HP] = power_level2 && !hp_q;

  // previous values for edge detection
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      fault_q <= 1'h0;
      los_q <= 1'h0;
      sr_q <= 1'h0;
      oper_q <= 1'h0;
      hp_q <= 1'h0;
    end else if (ce) begin
      fault_q <= fault;
      los_q <= los;
      sr_q <= serial_ready;
      oper_q <= oper;
      hp_q <= power_level2;
    end
  end

  // -------------------------------------------------------------
  // transmitter state machine
  // -------------------------------------------------------------
  wire off_held = off_cnt == reset_cyc;

  // next transmitter state
  always_comb begin
    next_state = state;
    case (state)
      ls_warm: begin
        if (laser_fault_detect) begin
          next_state = ls_fault;
        end else if (st_done && !warm_start) begin
          next_state = ls_run;
        end
      end
      ls_run: begin
        if (laser_fault_detect) begin
          next_state = ls_fault;
        end
      end
      ls_fault: begin
        if (off_held && !laser_fault_detect) begin
          next_state = ls_warm;
        end
      end
      default: begin
        next_state = ls_warm;
      end
    endcase
  end

  // state, shut-off hold counter and warm-up start pulse
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state <= ls_warm;
      off_cnt <= '0;
      boot <= 1'h1;
      warm_start <= 1'h1;
    end else if (ce) begin
      state <= next_state;
      boot <= 1'h0;
      warm_start <= fault && next_state == ls_warm;
      if (!laser_off_request) begin
        off_cnt <= '0;
      end else if (!off_held) begin
        off_cnt <= off_cnt + `OMC_RST_CNT_W'(1);
      end
    end
  end

  // -------------------------------------------------------------
  // pin and optics outputs
  // -------------------------------------------------------------

  // open drain pins pull low while their flag is clear
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      laser_fault_flag_out <= 1'h0;
      laser_fault_flag_oe <= 1'h1;
      optical_input_lost_out <= 1'h0;
      optical_input_lost_oe <= 1'h1;
      module_missing <= 1'h0;
      laser_enable <= 1'h0;
      rx_rate_sel <= 1'h0;
      power_level2 <= 1'h0;
      serial_ready <= 1'h0;
    end else if (ce) begin
      laser_fault_flag_oe <= next_state != ls_fault;
      optical_input_lost_oe <= !rx_power_low;
      module_missing <= 1'h0;
      laser_enable <= next_state == ls_run &&
                      !laser_off_request &&
                      !ctrl[`OMC_CTRL_SOFT_OFF];
      rx_rate_sel <= rx_rate_pick;
      power_level2 <= ctrl[`OMC_CTRL_HP] && hp_done;
      serial_ready <= sr_done;
    end
  end

  // -------------------------------------------------------------
  // timers and memory
  // -------------------------------------------------------------

  // warm-up after reset or fault recovery
  omc_timer u_start_tmr (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .start(warm_start),
    .load_val(COOLED ? COOLED_CYCLES : START_CYCLES),
    .done(st_done)
  );

  // serial side comes up after its own delay
  omc_timer u_serial_tmr (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .start(boot),
    .load_val(SERIAL_READY_DELAY),
    .done(sr_done)
  );

  // level II entry delay from the enabling write
  omc_timer u_hp_tmr (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .start(hp_start),
    .load_val(COOLED ? COOLED_CYCLES :
              HIGH_POWER_ENTRY_DELAY),
    .done(hp_done)
  );

  // identification memory window
  omc_idmem u_idmem (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .we(mem_we),
    .waddr(id_idx(aw_addr)),
    .wdata(w_data),
    .wstrb(w_strb),
    .re(ar_fire),
    .raddr(id_idx(s_axi_araddr)),
    .rdata(mem_rdata)
  );

endmodule
`default_nettype wire

// file: tb/omc_host.sv
// host board model: pull-ups, presence sense and shut-off line
`timescale 1ns/1ps
`default_nettype none
module omc_host (
  // module pins
  input wire logic fault_oe,
  input wire logic fault_out,
  input wire logic los_oe,
  input wire logic los_out,
  input wire logic missing,
  // host controls
  input wire logic off_drive,
  input wire logic off_open,
  // resolved levels
  output logic fault_pin,
  output logic los_pin,
  output logic present,
  output logic off_line
);
  // released open-drain lines float up to the host rail
  assign fault_pin = fault_oe ? fault_out : 1'h1;
  assign los_pin = los_oe ? los_out : 1'h1;
  assign present = !missing;
  // an undriven shut-off line reads high
  assign off_line = off_open | off_drive;
endmodule
`default_nettype wire

// file: tb/omc_props.sv
// port checker for the optical module control block
`timescale 1ns/1ps
`default_nettype none
`include "omc_map.svh"
module omc_props #(
  parameter logic [`OMC_TMR_W-1:0] SERIAL_READY_DELAY = 36'ha
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // pins
  input wire logic laser_off_request,
  input wire logic rx_rate_pick,
  input wire logic laser_fault_detect,
  input wire logic rx_power_low,
  input wire logic module_missing,
  input wire logic laser_fault_flag_oe,
  input wire logic optical_input_lost_oe,
  input wire logic laser_enable,
  input wire logic rx_rate_sel,
  input wire logic serial_ready
);
  logic [`OMC_TMR_W-1:0] cyc;
  logic [11:0] held;
  // ----------------------------------------
  // cycles since release, shut-off hold length
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    cyc <= rstn ? cyc + 1'b1 : '0;
    held <= (rstn && laser_off_request) ? held + {11'h0, ~&held} : 12'h0;
  end
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_FAULT_SET: assert property (
    laser_fault_detect |=> !laser_fault_flag_oe)
    else $error("fault flag not raised");
  AST_FAULT_CLR: assert property (
    $rose(laser_fault_flag_oe) |->
      $past(held) >= `OMC_RST_CNT_W'(`OMC_T_RESET_CYC))
    else $error("fault flag cleared too soon");
  AST_TX_OFF: assert property (
    laser_off_request [*2] |=> !laser_enable)
    else $error("laser on while shut off");
  AST_TX_FAULT: assert property (
    !laser_fault_flag_oe |-> !laser_enable)
    else $error("laser on during fault");
  AST_MISSING: assert property (
    module_missing == 1'h0)
    else $error("presence pin not grounded");
  AST_RATE: assert property (
    1'h1 |=> rx_rate_sel == $past(rx_rate_pick))
    else $error("rate select wrong");
  AST_LOS: assert property (
    1'h1 |=> optical_input_lost_oe == !$past(rx_power_low))
    else $error("loss flag wrong");
  AST_SER_EARLY: assert property (
    serial_ready |-> cyc >= SERIAL_READY_DELAY - 1'b1)
    else $error("serial ready too early");
  AST_SER_LATE: assert property (
    cyc > SERIAL_READY_DELAY + 3'h4 |-> serial_ready)
    else $error("serial ready too late");
endmodule
bind omc_ctrl omc_props #(.SERIAL_READY_DELAY(SERIAL_READY_DELAY)) u_props (
  .ref_clk, .rstn, .laser_off_request, .rx_rate_pick, .laser_fault_detect,
  .rx_power_low, .module_missing, .laser_fault_flag_oe,
  .optical_input_lost_oe, .laser_enable, .rx_rate_sel, .serial_ready);
`default_nettype wire

// file: tb/omc_ctrl_tb.sv
// self-checking bench for the optical module control block
`timescale 1ns/1ps
`default_nettype none
`include "omc_map.svh"
module omc_ctrl_tb;
  logic ref_clk, rstn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic laser_off_request, rx_rate_pick, tx_rate_pick, module_missing;
  logic laser_fault_flag_in, laser_fault_flag_out, laser_fault_flag_oe;
  logic optical_input_lost_in, optical_input_lost_out, optical_input_lost_oe;
  logic laser_fault_detect, rx_power_low, laser_enable, rx_rate_sel;
  logic power_level2, serial_ready, irq, off_drive, off_open, present;
  int fails, tests_run, k;
  logic [31:0] idq[$];
  // short counts keep the run brief
  omc_ctrl #(.COOLED(1'h0), .START_CYCLES(36'h14), .COOLED_CYCLES(36'h1e),
    .SERIAL_READY_DELAY(36'ha), .HIGH_POWER_ENTRY_DELAY(36'hf)) DUT (
    .ref_clk, .rstn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .laser_off_request, .rx_rate_pick, .tx_rate_pick, .module_missing,
    .laser_fault_flag_in, .laser_fault_flag_out, .laser_fault_flag_oe,
    .optical_input_lost_in, .optical_input_lost_out, .optical_input_lost_oe,
    .laser_fault_detect, .rx_power_low, .laser_enable, .rx_rate_sel,
    .power_level2, .serial_ready, .irq);
  omc_host HOST (.fault_oe(laser_fault_flag_oe),
    .fault_out(laser_fault_flag_out), .los_oe(optical_input_lost_oe),
    .los_out(optical_input_lost_out), .missing(module_missing),
    .off_drive(off_drive), .off_open(off_open),
    .fault_pin(laser_fault_flag_in), .los_pin(optical_input_lost_in),
    .present(present), .off_line(laser_off_request));
  // 200 MHz clock
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task report_and_stop;
    $display("checks %0d errors %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tmo(input int n);
    if (k >= n) begin
      fails++;
      report_and_stop;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (k = 0; k < 64; k++) begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'h0;
    r = s_axi_bresp;
    tmo(64);
  endtask
  task rd(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (k = 0; k < 64; k++) begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    tmo(64);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, tx_rate_pick, rx_rate_pick} = 4'h0;
    {laser_fault_detect, rx_power_low, off_drive} = 3'h0;
    {ce, off_open} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    void'($urandom(67));
    repeat (16) @(posedge ref_clk);
    rstn <= 1'h1;
    // identification reads refused until the serial side is up
    rd(`OMC_OFF_ID);
    chk(r, 2'h2);
    for (k = 0; k < 30 && !serial_ready; k++) @(posedge ref_clk);
    tmo(30);
    repeat (24) @(posedge ref_clk);
    chk(present, 1'h1);
    chk(laser_enable, 1'h0);
    // laser starts once the line is driven low, follows shut-off
    off_open <= 1'h0;
    for (k = 0; k < 40 && !laser_enable; k++) @(posedge ref_clk);
    tmo(40);
    off_drive <= 1'h1;
    repeat (3) @(posedge ref_clk);
    chk(laser_enable, 1'h0);
    off_drive <= 1'h0;
    repeat (3) @(posedge ref_clk);
    chk(laser_enable, 1'h1);
    // random rate picks and received power
    for (int i = 0; i < 24; i++) begin
      rx_rate_pick <= 1'($urandom);
      tx_rate_pick <= 1'($urandom);
      rx_power_low <= 1'($urandom);
      repeat (2) @(posedge ref_clk);
      chk(rx_rate_sel, rx_rate_pick);
      chk(optical_input_lost_in, rx_power_low);
      chk(laser_enable, 1'h1);
    end
    // loss event raises, masks and clears the interrupt
    rx_power_low <= 1'h0;
    wr(`OMC_OFF_EVEN, 32'h2);
    wr(`OMC_OFF_EVCLR, 32'h3f);
    rd(`OMC_OFF_EVENT);
    chk(d, 32'h0);
    chk(irq, 1'h0);
    rx_power_low <= 1'h1;
    repeat (4) @(posedge ref_clk);
    chk(irq, 1'h1);
    wr(`OMC_OFF_EVEN, 32'h0);
    chk(irq, 1'h0);
    wr(`OMC_OFF_EVEN, 32'h2);
    chk(irq, 1'h1);
    wr(`OMC_OFF_EVCLR, 32'h2);
    chk(irq, 1'h0);
    // identification memory against a queue model
    for (int i = 0; i < 4; i++) begin
      idq.push_back($urandom);
      wr(`OMC_OFF_ID + 8'(4 * i), idq[i]);
    end
    for (int i = 0; i < 4; i++) begin
      rd(`OMC_OFF_ID + 8'(4 * i));
      chk(d, idq.pop_front());
    end
    rd(8'h20);
    chk({d[29:0], r}, 32'h2);
    // fault latches until shut-off is held long enough
    laser_fault_detect <= 1'h1;
    @(posedge ref_clk);
    laser_fault_detect <= 1'h0;
    repeat (2) @(posedge ref_clk);
    chk(laser_fault_flag_in, 1'h1);
    chk(laser_enable, 1'h0);
    off_drive <= 1'h1;
    repeat (1000) @(posedge ref_clk);
    chk(laser_fault_flag_in, 1'h1);
    repeat (1010) @(posedge ref_clk);
    chk(laser_fault_flag_in, 1'h0);
    off_drive <= 1'h0;
    for (k = 0; k < 40 && !laser_enable; k++) @(posedge ref_clk);
    tmo(40);
    // power level two only after the enabling write
    chk(power_level2, 1'h0);
    wr(`OMC_OFF_CTRL, 32'h1);
    chk(r, `OMC_RESP_OKAY);
    for (k = 0; k < 30 && !power_level2; k++) @(posedge ref_clk);
    tmo(30);
    rd(`OMC_OFF_CTRL);
    chk(d, 32'h1);
    report_and_stop;
  end
endmodule
`default_nettype wire
